// ---- inc/lpmc_pkg.sv ----
// Shared constants and types for the LED pump mode control block
package lpmc_pkg;

  // Channel and register geometry
  localparam int NUM_CH = 6;
  localparam int NUM_PAIRS = 3;
  localparam int REG_W = 8;
  localparam int CODE_W = 6;
  localparam int APB_DW = 32;
  localparam int APB_AW = 8;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_PAIR_A = 3'h0;
  localparam logic [2:0] IDX_PAIR_B = 3'h1;
  localparam logic [2:0] IDX_PAIR_C = 3'h2;
  localparam logic [2:0] IDX_ON_OFF = 3'h3;

  // Values after reset and in shutdown
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [APB_DW-1:0] RST_RDATA = 32'h0000_0000;

  // Mode change delay
  localparam int PUMP_DELAY_US = 400;
  localparam int CLK_FREQ_MHZ = 10;
  localparam int PUMP_DELAY_CYC = PUMP_DELAY_US * CLK_FREQ_MHZ;
  localparam int DLY_W = 12;

  typedef enum logic [1:0] {
    PUMP_OFF,
    PUMP_1X,
    PUMP_1P5X
  } lpmc_mode_e;

  typedef struct packed {
    logic on;
    logic [CODE_W-1:0] code;
  } lpmc_sink_drive_s;

  // Word index of a byte address
  function automatic logic [2:0] lpmc_reg_index(input logic [APB_AW-1:0] addr);
    return addr[4:2];
  endfunction : lpmc_reg_index

  // Aligned and inside the map
  function automatic logic lpmc_addr_ok(input logic [APB_AW-1:0] addr);
    return (addr[1:0] == 2'h0) && (addr[APB_AW-1:5] == '0) &&
      (addr[4:2] <= IDX_ON_OFF);
  endfunction : lpmc_addr_ok

endpackage : lpmc_pkg

// ---- verilog/lpmc_sync3.sv ----
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lpmc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin side
  input wire logic [W-1:0] pin_in,
  // Core side
  output logic [W-1:0] level
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ff1 <= RST_VAL;
      ff2 <= RST_VAL;
      ff3 <= RST_VAL;
    end else begin
      ff1 <= pin_in;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // Only a value seen on two stages counts, so one-sample glitches die here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (ff2[i] == ff3[i]) begin
          level[i] <= ff3[i];
        end
      end
    end
  end

endmodule : lpmc_sync3
`default_nettype wire

// ---- verilog/lpmc_led_ctrl.sv ----
// LED driver control: APB registers, channel gating and pump mode sequencer
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Undervoltage forces every sink channel off
// - Enable rise starts active with zero current
// - Enable low holds zero-current shutdown
// - Four registers, all writable and readable
// - Pair register sets both channels' current
// - Mask switches each channel individually
// - Shutdown puts all sinks high impedance
// - Every mode sequence starts in 1x
// - Stay 1x while regulation holds
// - Regulation loss moves to 1.5x after 400us
// - Restart on power-up, enable, mask write
// - Low six bits code; current (code+1) steps
// - Mask bits 0..5 map A1..C2, one on
// - Four 8-bit registers at indices 0..3
module lpmc_led_ctrl
  import lpmc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analogue indications
  input wire logic chip_en,
  input wire logic supply_uv,
  input wire logic regulation_ok,
  // Sink and pump controls
  output lpmc_sink_drive_s [NUM_CH-1:0] led_sink_outputs,
  output logic [NUM_CH-1:0] sink_oe,
  output logic pump_mode_1p5x,
  output logic pump_run
);

  logic en_level;
  logic uv_level;
  logic reg_ok_level;
  lpmc_mode_e pump_state;
  logic [DLY_W-1:0] fail_cnt;
  logic enabled;
  logic [REG_W-1:0] pair_a_current_reg;
  logic [REG_W-1:0] pair_b_current_reg;
  logic [REG_W-1:0] pair_c_current_reg;
  logic [REG_W-1:0] channel_on_off_reg;
  logic [NUM_PAIRS-1:0][CODE_W-1:0] pair_codes;
  logic [2:0] reg_idx;
  logic addr_ok;
  logic wr_access;
  logic rd_setup;
  logic onoff_wr;
  logic [REG_W-1:0] rd_mux;

  // Supply comparator reset value 1 keeps sinks off until it is seen
  lpmc_sync3 #(
    .W(3),
    .RST_VAL(3'b110)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({regulation_ok, supply_uv, chip_en}),
    .level({reg_ok_level, uv_level, en_level})
  );

  assign enabled = (pump_state != PUMP_OFF);
  assign reg_idx = lpmc_reg_index(paddr);
  assign addr_ok = lpmc_addr_ok(paddr);
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign onoff_wr = wr_access && addr_ok && (reg_idx == IDX_ON_OFF) && enabled;

  // Zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Pump mode sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_state <= PUMP_OFF;
      fail_cnt <= '0;
    end else if (!en_level) begin
      pump_state <= PUMP_OFF;
      fail_cnt <= '0;
    end else begin
      case (pump_state)
        PUMP_OFF: begin
          pump_state <= PUMP_1X;
          fail_cnt <= '0;
        end
        PUMP_1X: begin
          if (onoff_wr || reg_ok_level) begin
            fail_cnt <= '0;
          end else if (fail_cnt == DLY_W'(PUMP_DELAY_CYC - 1)) begin
            pump_state <= PUMP_1P5X;
            fail_cnt <= '0;
          end else begin
            fail_cnt <= fail_cnt + 1'b1;
          end
        end
        PUMP_1P5X: begin
          if (onoff_wr) begin
            pump_state <= PUMP_1X;
          end
          fail_cnt <= '0;
        end
        default: begin
          pump_state <= PUMP_OFF;
          fail_cnt <= '0;
        end
      endcase
    end
  end

  // Registers; cleared in shutdown so currents start at zero on enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_a_current_reg <= RST_REG;
      pair_b_current_reg <= RST_REG;
      pair_c_current_reg <= RST_REG;
      channel_on_off_reg <= RST_REG;
    end else if (!enabled) begin
      pair_a_current_reg <= RST_REG;
      pair_b_current_reg <= RST_REG;
      pair_c_current_reg <= RST_REG;
      channel_on_off_reg <= RST_REG;
    end else if (wr_access && addr_ok) begin
      case (reg_idx)
        IDX_PAIR_A: pair_a_current_reg <= pwdata[REG_W-1:0];
        IDX_PAIR_B: pair_b_current_reg <= pwdata[REG_W-1:0];
        IDX_PAIR_C: pair_c_current_reg <= pwdata[REG_W-1:0];
        IDX_ON_OFF: channel_on_off_reg <= pwdata[REG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; only the four register words exist
  always_comb begin
    rd_mux = RST_REG;
    case (reg_idx)
      IDX_PAIR_A: rd_mux = pair_a_current_reg;
      IDX_PAIR_B: rd_mux = pair_b_current_reg;
      IDX_PAIR_C: rd_mux = pair_c_current_reg;
      IDX_ON_OFF: rd_mux = channel_on_off_reg;
      default: rd_mux = RST_REG;
    endcase
  end

  // Captured in setup so the access phase sees stable data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= RST_RDATA;
    end else if (rd_setup) begin
      prdata <= addr_ok ? {{(APB_DW - REG_W){1'b0}}, rd_mux} : RST_RDATA;
    end
  end

  // Bits 7:6 kept for read-back but never reach a sink
  assign pair_codes[0] = pair_a_current_reg[CODE_W-1:0];
  assign pair_codes[1] = pair_b_current_reg[CODE_W-1:0];
  assign pair_codes[2] = pair_c_current_reg[CODE_W-1:0];

  // Channel gating; channel i belongs to pair i/2
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_sink_outputs <= '0;
      sink_oe <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (channel_on_off_reg[i] && enabled && !uv_level) begin
          led_sink_outputs[i].on <= 1'b1;
          led_sink_outputs[i].code <= pair_codes[i / 2];
        end else begin
          led_sink_outputs[i].on <= 1'b0;
          led_sink_outputs[i].code <= '0;
        end
      end
      sink_oe <= {NUM_CH{enabled}};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_mode_1p5x <= 1'b0;
      pump_run <= 1'b0;
    end else begin
      pump_mode_1p5x <= (pump_state == PUMP_1P5X);
      pump_run <= enabled;
    end
  end

  // Checks
  property p_uv_off;
    @(posedge core_clk) disable iff (!rst_n)
      uv_level |=> (led_sink_outputs[0].on == 1'b0) && (led_sink_outputs[1].on == 1'b0) &&
        (led_sink_outputs[2].on == 1'b0) && (led_sink_outputs[3].on == 1'b0) &&
        (led_sink_outputs[4].on == 1'b0) && (led_sink_outputs[5].on == 1'b0);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("sink on under undervoltage");

  property p_enable_zero;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(enabled) |-> (channel_on_off_reg == RST_REG) && (pair_a_current_reg == RST_REG);
  endproperty
  a_enable_zero: assert property (p_enable_zero) else $error("not zero at enable");

  property p_shutdown;
    @(posedge core_clk) disable iff (!rst_n)
      !en_level |=> (pump_state == PUMP_OFF) ##1 (sink_oe == '0) && !pump_run;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("enable low, not off");

  property p_read_back;
    @(posedge core_clk) disable iff (!rst_n)
      (rd_setup && addr_ok && (reg_idx == IDX_ON_OFF)) |=>
        (prdata[REG_W-1:0] == $past(channel_on_off_reg)) && (prdata[APB_DW-1:REG_W] == '0);
  endproperty
  a_read_back: assert property (p_read_back) else $error("mask read-back wrong");

  property p_pair_code;
    @(posedge core_clk) disable iff (!rst_n)
      led_sink_outputs[3].on |-> (led_sink_outputs[3].code == $past(pair_b_current_reg[5:0])) &&
        (!led_sink_outputs[2].on || (led_sink_outputs[2].code == led_sink_outputs[3].code));
  endproperty
  a_pair_code: assert property (p_pair_code) else $error("pair code mismatch");

  property p_gate;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (led_sink_outputs[4].on ==
        $past(channel_on_off_reg[4] && enabled && !uv_level));
  endproperty
  a_gate: assert property (p_gate) else $error("channel gating wrong");

  property p_start_1x;
    @(posedge core_clk) disable iff (!rst_n)
      ((pump_state == PUMP_OFF) && en_level) |=> (pump_state == PUMP_1X) && (fail_cnt == '0);
  endproperty
  a_start_1x: assert property (p_start_1x) else $error("sequence did not start in 1x");

  property p_hold_1x;
    @(posedge core_clk) disable iff (!rst_n)
      ((pump_state == PUMP_1X) && reg_ok_level) |=> (pump_state != PUMP_1P5X);
  endproperty
  a_hold_1x: assert property (p_hold_1x) else $error("left 1x with regulation good");

  property p_delay;
    @(posedge core_clk) disable iff (!rst_n)
      $rose(pump_state == PUMP_1P5X) |->
        ($past(fail_cnt) == DLY_W'(PUMP_DELAY_CYC - 1)) && !$past(reg_ok_level);
  endproperty
  a_delay: assert property (p_delay) else $error("1.5x entered before delay");

  property p_restart;
    @(posedge core_clk) disable iff (!rst_n)
      (onoff_wr && en_level) |=> (pump_state == PUMP_1X) && (fail_cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("mask write did not restart");

  property p_stay_1p5;
    @(posedge core_clk) disable iff (!rst_n)
      ((pump_state == PUMP_1P5X) && en_level && !onoff_wr) |=> (pump_state == PUMP_1P5X);
  endproperty
  a_stay_1p5: assert property (p_stay_1p5) else $error("left 1.5x without restart");

  property p_off_code_zero;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |-> (led_sink_outputs[0].on || (led_sink_outputs[0].code == '0)) &&
        (led_sink_outputs[1].on || (led_sink_outputs[1].code == '0)) &&
        (led_sink_outputs[2].on || (led_sink_outputs[2].code == '0)) &&
        (led_sink_outputs[3].on || (led_sink_outputs[3].code == '0)) &&
        (led_sink_outputs[4].on || (led_sink_outputs[4].code == '0)) &&
        (led_sink_outputs[5].on || (led_sink_outputs[5].code == '0));
  endproperty
  a_off_code_zero: assert property (p_off_code_zero) else $error("off sink has code");

  property p_cleared_off;
    @(posedge core_clk) disable iff (!rst_n)
      !enabled |=> (channel_on_off_reg == RST_REG) && (pair_a_current_reg == RST_REG) &&
        (pair_b_current_reg == RST_REG) && (pair_c_current_reg == RST_REG);
  endproperty
  a_cleared_off: assert property (p_cleared_off) else $error("kept in shutdown");

  property p_bad_write;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_access && !addr_ok && enabled) |=> $stable(channel_on_off_reg) &&
        $stable(pair_a_current_reg) && $stable(pair_b_current_reg) &&
        $stable(pair_c_current_reg);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("bad address wrote");

  property p_oe_off;
    @(posedge core_clk) disable iff (!rst_n)
      !pump_run |-> (sink_oe == '0) && !pump_mode_1p5x;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("sink driven while off");

  property p_count_1x;
    @(posedge core_clk) disable iff (!rst_n)
      ((pump_state == PUMP_1X) && en_level && !reg_ok_level && !onoff_wr &&
        (fail_cnt != DLY_W'(PUMP_DELAY_CYC - 1))) |=>
        (pump_state == PUMP_1X) && (fail_cnt == $past(fail_cnt) + 1'b1);
  endproperty
  a_count_1x: assert property (p_count_1x) else $error("delay count stalled");

endmodule : lpmc_led_ctrl
`default_nettype wire

// ---- verification/lpmc_apb_host.sv ----
// APB host model standing in for the register link controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_apb_host
  import lpmc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Request side
  input wire logic req,
  input wire logic wr,
  input wire logic [APB_AW-1:0] addr,
  input wire logic [APB_DW-1:0] wdata,
  output logic done,
  output logic err,
  output logic [APB_DW-1:0] rdata,
  // APB side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {psel, penable, pwrite, done, err} <= '0;
      paddr <= '0;
      pwdata <= '0;
      rdata <= '0;
    end else begin
      done <= 1'b0;
      if (!psel && req) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (psel && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        // Stale data must not look valid after release
        pwdata <= ~pwdata;
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
      end
    end
  end
endmodule : lpmc_apb_host
`default_nettype wire

// ---- verification/lpmc_led_ctrl_tb.sv ----
// Self-checking bench for the LED pump mode control block
`timescale 1ns/1ps
`default_nettype none
module lpmc_led_ctrl_tb
  import lpmc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_en = 1'b0;
  logic supply_uv = 1'b0;
  logic regulation_ok = 1'b1;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [APB_AW-1:0] addr = '0;
  logic [APB_DW-1:0] wdata = '0;
  logic done, err, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] rdata, pwdata, prdata;
  lpmc_sink_drive_s [NUM_CH-1:0] sinks;
  logic [NUM_CH-1:0] sink_oe;
  logic mode_1p5, pump_run;
  logic [REG_W-1:0] regs [4];
  int fails = 0;
  int samples_checked = 0;
  int i;

  always #50 core_clk = ~core_clk;

  lpmc_apb_host host (.core_clk(core_clk), .rst_n(rst_n), .req(req), .wr(wr),
    .addr(addr), .wdata(wdata), .done(done), .err(err), .rdata(rdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  lpmc_led_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_en(chip_en),
    .supply_uv(supply_uv), .regulation_ok(regulation_ok),
    .led_sink_outputs(sinks), .sink_oe(sink_oe),
    .pump_mode_1p5x(mode_1p5), .pump_run(pump_run));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    addr <= a;
    wdata <= d;
    req <= 1'b1;
    @(posedge core_clk);
    req <= 1'b0;
    do @(posedge core_clk); while (done !== 1'b1 && ++n < 20);
    chk({31'h0, done}, 32'h1);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdata, e);
    chk({31'h0, err}, 32'h0);
  endtask : rd

  // Expected drive per channel from the bench's own register copy
  task automatic chk_sinks(input logic en);
    for (int k = 0; k < NUM_CH; k++) begin
      chk({25'h0, sinks[k]}, {25'h0, en && regs[3][k],
        (en && regs[3][k]) ? regs[k/2][5:0] : 6'h00});
    end
  endtask : chk_sinks

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #2000000;
    fails++;
    report_and_stop();
  end

  initial begin
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    xfer(1'b1, 8'h00, 32'h0000_003F);
    rd(8'h00, 32'h0);
    chk({26'h0, sink_oe}, 32'h0);
    chk({31'h0, pump_run}, 32'h0);
    $display("Test shutdown done");
    chip_en <= 1'b1;
    tick(10);
    chk({30'h0, pump_run, mode_1p5}, 32'h2);
    regs = '{8'h00, 8'h00, 8'h00, 8'h00};
    chk_sinks(1'b1);
    $display("Test enable done");
    // Upper bits carry junk that must read back as zero
    regs = '{8'hC5, 8'h3F, 8'h00, 8'h2D};
    for (i = 0; i < 4; i++) xfer(1'b1, 8'(i * 4), {24'hABCDEF, regs[i]});
    tick(2);
    chk_sinks(1'b1);
    for (i = 0; i < 4; i++) rd(8'(i * 4), {24'h0, regs[i]});
    xfer(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, 8'h01, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (i = 0; i < NUM_CH; i++) begin
      regs[3] = 8'(1 << i);
      xfer(1'b1, 8'h0C, {24'h0, regs[3]});
      tick(2);
      chk_sinks(1'b1);
    end
    $display("Test registers done");
    supply_uv <= 1'b1;
    tick(8);
    chk_sinks(1'b0);
    supply_uv <= 1'b0;
    tick(8);
    chk_sinks(1'b1);
    $display("Test undervoltage done");
    // Short loss must not leave a partial count behind
    regulation_ok <= 1'b0;
    tick(200);
    regulation_ok <= 1'b1;
    tick(10);
    regulation_ok <= 1'b0;
    tick(3990);
    chk({31'h0, mode_1p5}, 32'h0);
    tick(30);
    chk({31'h0, mode_1p5}, 32'h1);
    regulation_ok <= 1'b1;
    tick(20);
    chk({31'h0, mode_1p5}, 32'h1);
    xfer(1'b1, 8'h0C, {24'h0, regs[3]});
    tick(3);
    chk({31'h0, mode_1p5}, 32'h0);
    $display("Test pump mode done");
    regulation_ok <= 1'b0;
    tick(4030);
    chk({31'h0, mode_1p5}, 32'h1);
    chip_en <= 1'b0;
    regulation_ok <= 1'b1;
    tick(10);
    chk({24'h0, sink_oe, pump_run, mode_1p5}, 32'h0);
    rd(8'h0C, 32'h0);
    chip_en <= 1'b1;
    tick(10);
    chk({30'h0, pump_run, mode_1p5}, 32'h2);
    regs = '{8'h00, 8'h00, 8'h00, 8'h00};
    chk_sinks(1'b1);
    $display("Test re-enable done");
    report_and_stop();
  end
endmodule : lpmc_led_ctrl_tb
`default_nettype wire
